// [core/psci_phy_ctrl.v]
// phy service control: request execution, event indication, ahb-lite registers
`timescale 1ns/1ps
`include "psci_map.vh"
module psci_phy_ctrl (
  input  wire        i_clk,         // system clock, 50 MHz
  input  wire        i_sys_rst,     // async reset, active high
  input  wire        i_hsel,        // ahb slave select
  input  wire [31:0] i_haddr,       // ahb address
  input  wire [1:0]  i_htrans,      // ahb transfer type
  input  wire        i_hwrite,      // ahb write
  input  wire [2:0]  i_hsize,       // ahb size
  input  wire [31:0] i_hwdata,      // ahb write data
  input  wire        i_hready,      // ahb bus ready
  output reg  [31:0] o_hrdata,      // ahb read data
  output reg         o_hreadyout,   // ahb slave ready
  output reg         o_hresp,       // ahb response, always okay
  input  wire        i_rx_activity, // receive terminal activity detected
  input  wire        i_tx_data,     // serial data for the transmit terminal
  output reg         o_evt_valid,   // one-cycle event indication
  output reg  [7:0]  o_event_code,  // code of the indicated event
  output reg         o_bypass_open, // 1: bypass path open
  output reg         o_status,      // status pin, high means transmitter on
  output reg         o_ctrl_rst_n,  // reset pin toward transceiver, active low
  output wire        o_tx_p_o,      // transmit positive terminal level
  output wire        o_tx_p_oe,     // transmit positive terminal enable
  output wire        o_tx_n_o,      // transmit negative terminal level
  output wire        o_tx_n_oe      // transmit negative terminal enable
);

  localparam [1:0] HTRANS_NONSEQ = 2'b10;

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  reg                     tx_on_r;
  reg [`PSCI_CODE_W-1:0]  last_req_r;
  reg [`PSCI_CODE_W-1:0]  evt_code_r;
  reg                     evt_pend_r;
  reg                     evt_lost_r;
  reg                     act_q_r;
  reg                     act_seen_r;
  reg                     wr_ph_r;
  reg                     rd_ph_r;
  reg [`PSCI_ADDR_W-1:0]  ph_addr_r;

  wire addr_ok   = i_hsel & i_hready & (i_htrans == HTRANS_NONSEQ);
  wire req_wr    = wr_ph_r & (ph_addr_r == `PSCI_OFS_REQ);
  wire evt_clr   = wr_ph_r & (ph_addr_r == `PSCI_OFS_EVT) & i_hwdata[`PSCI_EVT_PEND_BIT];
  wire [7:0] req_code = i_hwdata[7:0];

  // ----------------------------------------------------------------------------
  // ahb-lite slave: writes zero-wait, reads one wait state so read data
  // always reflect a write that completed on the edge before
  // ----------------------------------------------------------------------------
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_ph_r     <= 1'b0;
      rd_ph_r     <= 1'b0;
      ph_addr_r   <= {`PSCI_ADDR_W{1'b0}};
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      o_hrdata    <= `PSCI_RST_DATA;
    end else begin
      o_hresp <= 1'b0;
      if (rd_ph_r) begin
        rd_ph_r     <= 1'b0;
        o_hreadyout <= 1'b1;
        case (ph_addr_r)
          `PSCI_OFS_REQ:  o_hrdata <= {24'h00_0000, last_req_r};
          `PSCI_OFS_EVT:  o_hrdata <= {22'h0_0000, evt_lost_r, evt_pend_r, evt_code_r};
          `PSCI_OFS_STAT: o_hrdata <= {29'h000_0000, i_rx_activity,
                                       o_bypass_open, tx_on_r};
          default:        o_hrdata <= `PSCI_RST_DATA;
        endcase
      end else begin
        wr_ph_r <= addr_ok & i_hwrite;
        if (addr_ok) begin
          ph_addr_r <= i_haddr[`PSCI_ADDR_W-1:0];
        end
        if (addr_ok & ~i_hwrite) begin
          rd_ph_r     <= 1'b1;
          o_hreadyout <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // request execution; unknown codes are recorded but change nothing
  // ----------------------------------------------------------------------------
  wire tx_going_off = req_wr & (req_code == `PSCI_REQ_TX_OFF) & tx_on_r;

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tx_on_r       <= `PSCI_RST_TX_ON;
      o_bypass_open <= `PSCI_RST_BYP_OPEN;
      last_req_r    <= `PSCI_EVT_NONE;
    end else if (req_wr) begin
      last_req_r <= req_code;
      case (req_code)
        `PSCI_REQ_TX_OFF:   tx_on_r <= 1'b0;
        `PSCI_REQ_TX_ON:    tx_on_r <= 1'b1;
        `PSCI_REQ_OPEN_BYP: o_bypass_open <= 1'b1;
        default:            tx_on_r <= tx_on_r;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // event indication: one code per pulse; a rising activity edge that meets
  // a transmitter-off event waits one cycle so neither is dropped
  // ----------------------------------------------------------------------------
  wire act_rise = i_rx_activity & ~act_seen_r;
  wire act_want = act_rise | act_q_r;
  reg  [7:0] evt_nxt;
  reg        evt_fire;

  always @* begin
    evt_fire = 1'b0;
    evt_nxt  = `PSCI_EVT_NONE;
    if (tx_going_off) begin
      evt_fire = 1'b1;
      evt_nxt  = `PSCI_EVT_TX_OFF;
    end else if (act_want) begin
      evt_fire = 1'b1;
      evt_nxt  = `PSCI_EVT_RX_ACT;
    end
  end

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      act_seen_r   <= 1'b0;
      act_q_r      <= 1'b0;
      o_evt_valid  <= 1'b0;
      o_event_code <= `PSCI_EVT_NONE;
      evt_code_r   <= `PSCI_EVT_NONE;
      evt_pend_r   <= 1'b0;
      evt_lost_r   <= 1'b0;
    end else begin
      act_seen_r  <= i_rx_activity;
      act_q_r     <= act_want & tx_going_off;
      o_evt_valid <= evt_fire;
      if (evt_fire) begin
        o_event_code <= evt_nxt;
        evt_code_r   <= evt_nxt;
      end
      // pending: set wins over a clear in the same cycle; lost: the clear wins
      if (evt_fire) begin
        evt_pend_r <= 1'b1;
      end else if (evt_clr) begin
        evt_pend_r <= 1'b0;
      end
      if (evt_fire & evt_pend_r & ~evt_clr) begin
        evt_lost_r <= 1'b1;
      end else if (evt_clr) begin
        evt_lost_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // single-ended pins: high is logic one
  // ----------------------------------------------------------------------------
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_status     <= 1'b0;
      o_ctrl_rst_n <= 1'b0;
    end else begin
      o_status     <= tx_on_r;
      o_ctrl_rst_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // transmit terminal
  // ----------------------------------------------------------------------------
  psci_lvds_drv u_drv (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_en      (tx_on_r),
    .i_data    (i_tx_data),
    .o_p_o     (o_tx_p_o),
    .o_p_oe    (o_tx_p_oe),
    .o_n_o     (o_tx_n_o),
    .o_n_oe    (o_tx_n_oe)
  );

endmodule

// [core/psci_map.vh]
// constants for the phy service control block: codes, register map, reset values
`ifndef PSCI_MAP_VH
`define PSCI_MAP_VH

// ----------------------------------------------------------------------------
// enumeration codes
// ----------------------------------------------------------------------------
`define PSCI_CODE_W          8
`define PSCI_EVT_NONE        8'h00
`define PSCI_EVT_TX_OFF      8'h01
`define PSCI_EVT_RX_ACT      8'h02
`define PSCI_REQ_TX_OFF      8'h01
`define PSCI_REQ_TX_ON       8'h02
`define PSCI_REQ_OPEN_BYP    8'h03

// ----------------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------------
`define PSCI_ADDR_W          12
`define PSCI_OFS_REQ         12'h000
`define PSCI_OFS_EVT         12'h004
`define PSCI_OFS_STAT        12'h008

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define PSCI_EVT_PEND_BIT    8
`define PSCI_EVT_LOST_BIT    9
`define PSCI_STAT_TXON_BIT   0
`define PSCI_STAT_BYP_BIT    1
`define PSCI_STAT_RXACT_BIT  2

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define PSCI_RST_TX_ON       1'b0
`define PSCI_RST_BYP_OPEN    1'b0
`define PSCI_RST_DATA        32'h0000_0000

`endif

// [core/psci_lvds_drv.v]
// registered tri-state differential output stage
`timescale 1ns/1ps
module psci_lvds_drv (
  input  wire i_clk,     // system clock
  input  wire i_sys_rst, // async reset, active high
  input  wire i_en,      // 1: drive the line
  input  wire i_data,    // bit to send
  output reg  o_p_o,     // positive terminal level
  output reg  o_p_oe,    // positive terminal enable
  output reg  o_n_o,     // negative terminal level
  output reg  o_n_oe     // negative terminal enable
);

  // ----------------------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------------------
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_p_o  <= 1'b0;
      o_n_o  <= 1'b0;
      o_p_oe <= 1'b0;
      o_n_oe <= 1'b0;
    end else if (i_en) begin
      o_p_oe <= 1'b1;
      o_n_oe <= 1'b1;
      o_p_o  <= i_data;
      o_n_o  <= ~i_data;
    end else begin
      // levels parked low so a released pin carries no stale data
      o_p_oe <= 1'b0;
      o_n_oe <= 1'b0;
      o_p_o  <= 1'b0;
      o_n_o  <= 1'b0;
    end
  end

endmodule

// [tb/psci_line_model.sv]
// line-side stand-in: serial data source and receive activity
`timescale 1ns/1ps
module psci_line_model (
  input  wire i_clk,     // system clock
  input  wire i_act,     // bench asks for receive activity
  output reg  o_rx_act,  // receive terminal activity
  output reg  o_tx_data  // serial bit toward the transmit terminal
);
  initial begin
    o_rx_act = 1'b0;
    o_tx_data = 1'b0;
  end
  // data flips every cycle so a stuck terminal never matches by luck
  always @(posedge i_clk) begin
    o_tx_data <= ~o_tx_data;
    o_rx_act  <= i_act;
  end
endmodule

// [tb/psci_phy_ctrl_sva.sv]
// concurrent checks on the phy service control ports
`timescale 1ns/1ps
module psci_phy_ctrl_sva (
  input wire       i_clk,
  input wire       i_sys_rst,
  input wire       i_hsel,
  input wire [1:0] i_htrans,
  input wire       i_hwrite,
  input wire       i_hready,
  input wire       i_rx_activity,
  input wire       i_tx_data,
  input wire       o_hreadyout,
  input wire       o_evt_valid,
  input wire [7:0] o_event_code,
  input wire       o_bypass_open,
  input wire       o_status,
  input wire       o_ctrl_rst_n,
  input wire       o_tx_p_o,
  input wire       o_tx_p_oe,
  input wire       o_tx_n_o,
  input wire       o_tx_n_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  sequence rd_taken;
    i_hsel && i_hready && i_htrans == 2'b10 && !i_hwrite;
  endsequence
  sequence one_wait;
    !o_hreadyout ##1 o_hreadyout;
  endsequence
  chk_read_wait:
    assert property (rd_taken |=> one_wait) else $error("read wait state wrong");
  chk_evt_code:
    assert property (o_evt_valid |-> o_event_code == 8'h01 || o_event_code == 8'h02)
    else $error("event code out of range");
  chk_txoff_evt:
    assert property ($fell(o_status) |-> $past(o_evt_valid) && $past(o_event_code) == 8'h01)
    else $error("transmitter off without event");
  chk_act_evt:
    assert property ($rose(i_rx_activity) |-> ##[1:3] (o_evt_valid && o_event_code == 8'h02))
    else $error("activity event missing");
  chk_diff_pol:
    assert property (o_tx_p_oe |-> o_tx_p_o == $past(i_tx_data) && o_tx_n_o == !o_tx_p_o)
    else $error("differential polarity wrong");
  chk_both_z:
    assert property (!o_tx_p_oe |-> !o_tx_n_oe && !o_tx_p_o && !o_tx_n_o)
    else $error("terminal driven while off");
  chk_oe_status:
    assert property (o_tx_p_oe == o_status && o_tx_n_oe == o_status)
    else $error("enables disagree with status");
  chk_byp_hold:
    assert property ($past(o_bypass_open) |-> o_bypass_open) else $error("bypass closed");
  chk_rst_pin:
    assert property (!$past(i_sys_rst) |-> o_ctrl_rst_n) else $error("reset pin low");
endmodule
bind psci_phy_ctrl psci_phy_ctrl_sva u_sva (.i_clk, .i_sys_rst, .i_hsel, .i_htrans,
  .i_hwrite, .i_hready, .i_rx_activity, .i_tx_data, .o_hreadyout, .o_evt_valid,
  .o_event_code, .o_bypass_open, .o_status, .o_ctrl_rst_n, .o_tx_p_o, .o_tx_p_oe,
  .o_tx_n_o, .o_tx_n_oe);

// [tb/phy_service_control_interface_tb.sv]
// self-checking bench for the phy service control block
`timescale 1ns/1ps
module phy_service_control_interface_tb;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         hsel = 1'b0;
  reg         hwrite = 1'b0;
  reg         act = 1'b0;
  reg  [1:0]  htrans = 2'b00;
  reg  [31:0] haddr = 32'h0000_0000;
  reg  [31:0] hwdata = 32'h0000_0000;
  reg  [31:0] rd;
  reg  [7:0]  last_evt = 8'h00;
  wire        hrdy, hresp, evt_v, byp, stat, rstn, rx, txd, po, poe, no, noe;
  wire [31:0] hrdata;
  wire [7:0]  evt_code;
  integer     n_evt = 0;
  integer     evt_base = 0;
  integer     err_total = 0;
  integer     total_checks = 0;
  always #10 clk = ~clk;
  psci_phy_ctrl dut (.i_clk(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata),
    .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
    .i_rx_activity(rx), .i_tx_data(txd), .o_evt_valid(evt_v), .o_event_code(evt_code),
    .o_bypass_open(byp), .o_status(stat), .o_ctrl_rst_n(rstn), .o_tx_p_o(po),
    .o_tx_p_oe(poe), .o_tx_n_o(no), .o_tx_n_oe(noe));
  psci_line_model u_line (.i_clk(clk), .i_act(act), .o_rx_act(rx), .o_tx_data(txd));
  always @(posedge clk) if (evt_v === 1'b1) begin
    last_evt <= evt_code;
    n_evt <= n_evt + 1;
  end
  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task check(input [31:0] seen, input [31:0] exp, input string nm);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task ahb(input wr, input [11:0] a, input [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {20'h0_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
    check(hresp, 1'b0, "hresp");
  endtask
  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task t_reset;
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    check(rstn, 1'b0, "reset pin low");
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check(stat, 1'b0, "status");
    check({poe, noe, po, no}, 4'h0, "tx pins");
    check(byp, 1'b0, "bypass");
    check(rstn, 1'b1, "reset pin");
    ahb(1'b0, 12'h008, 32'h0000_0000);
    check(rd, 32'h0000_0000, "stat reg");
  endtask
  task t_tx_on;
    ahb(1'b1, 12'h000, 32'h0000_0002);
    settle;
    check({stat, poe, noe}, 3'b111, "tx on");
    check({po, no}, {~txd, txd}, "tx levels");
    ahb(1'b0, 12'h008, 32'h0000_0000);
    check(rd[0], 1'b1, "stat tx");
  endtask
  task t_tx_off;
    ahb(1'b1, 12'h000, 32'h0000_0001);
    settle;
    check(last_evt, 8'h01, "off event");
    check(stat, 1'b0, "tx off");
    check({poe, noe, po, no}, 4'h0, "tx pins off");
    ahb(1'b0, 12'h004, 32'h0000_0000);
    check(rd[9:0], 10'h101, "evt reg");
    ahb(1'b1, 12'h000, 32'h0000_0001);
    settle;
    check(n_evt, 1, "event count");
  endtask
  task t_activity;
    @(posedge clk);
    act <= 1'b1;
    settle;
    check(last_evt, 8'h02, "act event");
    ahb(1'b0, 12'h008, 32'h0000_0000);
    check(rd[2], 1'b1, "stat act");
    act <= 1'b0;
    ahb(1'b0, 12'h004, 32'h0000_0000);
    check(rd[9:0], 10'h302, "evt lost");
    ahb(1'b1, 12'h004, 32'h0000_0100);
    ahb(1'b0, 12'h004, 32'h0000_0000);
    check(rd[9:8], 2'b00, "evt clear");
  endtask
  task t_collide;
    ahb(1'b1, 12'h000, 32'h0000_0002);
    settle;
    evt_base = n_evt;
    // activity reaches the block in the data phase of the off request
    fork
      ahb(1'b1, 12'h000, 32'h0000_0001);
      begin
        @(posedge clk);
        act <= 1'b1;
      end
    join
    settle;
    check(n_evt - evt_base, 32'h0000_0002, "both events");
    check(last_evt, 8'h02, "activity after off");
    ahb(1'b0, 12'h004, 32'h0000_0000);
    check(rd[9:0], 10'h302, "collide evt reg");
    act <= 1'b0;
  endtask
  task t_bypass;
    ahb(1'b1, 12'h000, 32'h0000_0003);
    ahb(1'b0, 12'h008, 32'h0000_0000);
    check(rd[1:0], 2'b10, "stat bypass");
    check(byp, 1'b1, "bypass pin");
  endtask
  task t_odd;
    ahb(1'b1, 12'h000, 32'h0000_007F);
    ahb(1'b0, 12'h000, 32'h0000_0000);
    check(rd[7:0], 8'h7F, "odd code");
    ahb(1'b1, 12'h00C, 32'hFFFF_FFFF);
    ahb(1'b0, 12'h00C, 32'h0000_0000);
    check(rd, 32'h0000_0000, "unmapped");
    check({byp, stat}, 2'b10, "no action");
  endtask
  initial begin
    t_reset;
    t_tx_on;
    t_tx_off;
    t_activity;
    t_collide;
    t_bypass;
    t_odd;
    // a second reset must close the open bypass again
    t_reset;
    finish_test;
  end
  // a hang is cut off after 5000 cycles
  initial begin
    #100000;
    err_total = err_total + 1;
    finish_test;
  end
endmodule
